/* include/dcl_pkg.sv */
// Package of constants shared by the column loader control block.
package dcl_pkg;
    localparam int CHANNELS = 12;
    localparam int PIXEL_BITS = 10;
    localparam int SERIAL_BITS = 12;
    localparam int AUX_BITS = 8;
    localparam int LOAD_PERIODS = 6;
    localparam int BIT_UNUSED_LOW = 8;
    localparam int BIT_UNUSED_HIGH = 9;
    localparam int BIT_AUX_LOAD = 10;
    localparam int BIT_OUT_MODE = 11;
    localparam logic [9:0] CODE_MAX = 10'h3FF;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [9:0] PIXEL_RESET = 10'h000;
    localparam logic [3:0] LAST_CHANNEL = 4'hB;
    localparam logic [3:0] FIRST_CHANNEL = 4'h0;
    localparam logic [3:0] LOAD_COUNT = 4'hC;
    localparam logic [3:0] SERIAL_COUNT_MAX = 4'hC;
    localparam logic MODE_NORMAL = 1'b0;
    localparam logic MODE_GROUNDED = 1'b1;
endpackage : dcl_pkg

/* hw/dcl_loader.sv */
// Column loader control: pixel distribution, transfer and serial control.
`timescale 1ns/10ps
`default_nettype none
module dcl_loader #(
    parameter int CHANNELS = dcl_pkg::CHANNELS,
    parameter int PIXEL_BITS = dcl_pkg::PIXEL_BITS
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pixel stream, one word per rising clock edge, sampled here per enable.
    input wire logic pix_valid_i,
    input wire logic [PIXEL_BITS-1:0] pix_data_i,
    output logic pix_ready_o,
    // Video control pins.
    input wire logic transfer_start_strobe_i,
    input wire logic load_direction_i,
    input wire logic polarity_control_i,
    input wire logic thermal_switch_input_i,
    input wire logic mode_source_select_i,
    input wire logic ground_switch_input_i,
    // Serial control, sampled as ordinary synchronous inputs.
    input wire logic serial_frame_strobe_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_in_i,
    // Digital view of the outputs.
    output logic [CHANNELS*PIXEL_BITS-1:0] video_code_o,
    output logic [CHANNELS*PIXEL_BITS-1:0] video_level_code_o,
    output logic polarity_o,
    output logic grounded_o,
    output logic thermal_enable_o,
    output logic [7:0] aux_dac_code_o,
    output logic loading_o
);
    typedef enum logic [1:0] {
        DCL_IDLE = 2'b01,
        DCL_LOAD = 2'b10
    } dcl_state_t;

    dcl_state_t state;
    logic [3:0] load_count;
    logic [3:0] channel;
    logic strobe_seen;
    logic [PIXEL_BITS-1:0] latch_mem [CHANNELS];
    logic polarity_pending;
    logic serial_mode;
    logic [dcl_pkg::SERIAL_BITS-1:0] shift;
    logic frame_q;
    logic sclk_q;
    logic [1:0] buf_valid;
    logic [PIXEL_BITS-1:0] buf_data [2];
    logic buf_take;
    logic buf_push;
    logic [3:0] next_channel;
    logic load_down;
    logic load_last;
    logic frame_fall;
    logic frame_rise;
    logic sclk_rise;

    // The source delivers one word per clock edge through a two-entry
    // buffer; the loader drains it one word per cycle while loading.
    // Limitation: one word per block clock means twelve cycles per load,
    // so the block clock must run at twice the video clock to keep up with
    // a source that changes its word on both video clock edges.
    assign pix_ready_o = (buf_valid != 2'b11);
    assign buf_push = pix_valid_i && pix_ready_o;
    // No word is taken while a strobe is acted on, since the latch write is
    // held off then and the word would be lost.
    assign buf_take = buf_valid[0] && (state == DCL_LOAD) && !strobe_seen;
    assign loading_o = (state == DCL_LOAD);
    assign load_last = (load_count == dcl_pkg::LOAD_COUNT - 4'h1);
    assign frame_fall = frame_q && !serial_frame_strobe_i;
    assign frame_rise = !frame_q && serial_frame_strobe_i;
    assign sclk_rise = !serial_frame_strobe_i && serial_clock_i && !sclk_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_valid <= 2'b00;
            buf_data[0] <= dcl_pkg::PIXEL_RESET;
            buf_data[1] <= dcl_pkg::PIXEL_RESET;
        end else begin
            case ({buf_push, buf_take})
                2'b10: begin
                    if (!buf_valid[0]) begin
                        buf_data[0] <= pix_data_i;
                        buf_valid <= 2'b01;
                    end else begin
                        buf_data[1] <= pix_data_i;
                        buf_valid <= 2'b11;
                    end
                end
                2'b01: begin
                    buf_data[0] <= buf_data[1];
                    buf_valid <= {1'b0, buf_valid[1]};
                end
                2'b11: begin
                    if (buf_valid[1]) begin
                        buf_data[0] <= buf_data[1];
                        buf_data[1] <= pix_data_i;
                    end else begin
                        buf_data[0] <= pix_data_i;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Strobe is sampled on rising edges only; action follows next edge.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_seen <= 1'b0;
        end else begin
            strobe_seen <= transfer_start_strobe_i;
        end
    end

    // Direction is held for the whole sequence, so a change of the select
    // pin in mid-load cannot scatter words over the wrong channels.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_down <= 1'b0;
        end else if (strobe_seen) begin
            load_down <= load_direction_i;
        end
    end

    always_comb begin
        next_channel = channel;
        if (load_down) begin
            next_channel = channel - 4'h1;
        end else begin
            next_channel = channel + 4'h1;
        end
    end

    // Sequencer: idle until a strobe, then one channel per buffered word.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= DCL_IDLE;
        end else if (strobe_seen) begin
            state <= DCL_LOAD;
        end else begin
            case (state)
                DCL_LOAD: begin
                    if (buf_take && load_last) begin
                        state <= DCL_IDLE;
                    end
                end
                DCL_IDLE: begin
                end
                default: state <= DCL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            load_count <= 4'h0;
        end else if (strobe_seen) begin
            load_count <= 4'h0;
        end else if (buf_take) begin
            load_count <= load_count + 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel <= dcl_pkg::FIRST_CHANNEL;
        end else if (strobe_seen) begin
            channel <= load_direction_i ? dcl_pkg::LAST_CHANNEL
                                        : dcl_pkg::FIRST_CHANNEL;
        end else if (buf_take) begin
            channel <= next_channel;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    latch_mem[g] <= dcl_pkg::PIXEL_RESET;
                    video_code_o[g*PIXEL_BITS +: PIXEL_BITS] <=
                        dcl_pkg::PIXEL_RESET;
                end else begin
                    if (buf_take && !strobe_seen && channel == 4'(g)) begin
                        latch_mem[g] <= buf_data[0];
                    end
                    if (strobe_seen) begin
                        video_code_o[g*PIXEL_BITS +: PIXEL_BITS] <=
                            latch_mem[g];
                    end
                end
            end
            // Inverted code drives the level: full scale at code zero.
            assign video_level_code_o[g*PIXEL_BITS +: PIXEL_BITS] =
                grounded_o ? dcl_pkg::PIXEL_RESET
                : dcl_pkg::CODE_MAX -
                  video_code_o[g*PIXEL_BITS +: PIXEL_BITS];
        end
    endgenerate

    // The polarity caught now only reaches the outputs one transfer later.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            polarity_pending <= 1'b0;
        end else if (strobe_seen) begin
            polarity_pending <= polarity_control_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            polarity_o <= 1'b0;
        end else if (strobe_seen) begin
            polarity_o <= polarity_pending;
        end
    end

    // Frame and shift clock edges are found against the last samples; the
    // shift clock must stay below half the block clock or rises are missed.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_q <= 1'b1;
        end else begin
            frame_q <= serial_frame_strobe_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= serial_clock_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift <= '0;
        end else if (frame_fall) begin
            shift <= '0;
        end else if (sclk_rise) begin
            shift <= {shift[dcl_pkg::SERIAL_BITS-2:0],
                      serial_data_in_i};
        end
    end

    // The code moves only with the load bit set, so a word that sets the
    // mode alone leaves the auxiliary level where it was.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aux_dac_code_o <= dcl_pkg::AUX_RESET;
        end else if (frame_rise && shift[dcl_pkg::BIT_AUX_LOAD]) begin
            aux_dac_code_o <= shift[dcl_pkg::AUX_BITS-1:0];
        end
    end

    // Bits 8 and 9 are never read; with pin control the mode bit is dropped.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_mode <= dcl_pkg::MODE_NORMAL;
        end else if (frame_rise && mode_source_select_i) begin
            serial_mode <= shift[dcl_pkg::BIT_OUT_MODE];
        end
    end

    // Pin control acts at once; serial control keeps the last mode bit
    // until another frame completes.
    always_comb begin
        if (mode_source_select_i) begin
            grounded_o = serial_mode;
        end else begin
            grounded_o = !ground_switch_input_i;
        end
    end

    assign thermal_enable_o = thermal_switch_input_i;
    // The analog DAC computes low reference plus span times code/256.
endmodule : dcl_loader
`default_nettype wire

/* test/dcl_loader_props.sv */
// Checker of the column loader control ports.
`timescale 1ns/10ps
`default_nettype none
module dcl_props #(
    parameter int CHANNELS = 12,
    parameter int PIXEL_BITS = 10
) (
    // Clock, reset and control pins.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic transfer_start_strobe_i,
    input wire logic thermal_switch_input_i,
    input wire logic mode_source_select_i,
    input wire logic ground_switch_input_i,
    input wire logic serial_frame_strobe_i,
    // Observed outputs.
    input wire logic [CHANNELS*PIXEL_BITS-1:0] video_code_o,
    input wire logic [CHANNELS*PIXEL_BITS-1:0] video_level_code_o,
    input wire logic polarity_o,
    input wire logic grounded_o,
    input wire logic thermal_enable_o,
    input wire logic [7:0] aux_dac_code_o,
    input wire logic loading_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_LOAD_START: assert property (
        transfer_start_strobe_i |=> ##1 loading_o) else $error("no load");
    AST_XFER_ONLY: assert property (
        $changed(video_code_o) |-> $past(transfer_start_strobe_i, 2))
        else $error("outputs moved without strobe");
    AST_POL_ONLY: assert property (
        $changed(polarity_o) |-> $past(transfer_start_strobe_i, 2))
        else $error("polarity moved without strobe");
    AST_THERMAL: assert property (
        thermal_enable_o == thermal_switch_input_i) else $error("thermal");
    AST_PIN_MODE: assert property (
        !mode_source_select_i |-> grounded_o == !ground_switch_input_i)
        else $error("pin mode wrong");
    AST_GND_LEVEL: assert property (
        grounded_o |-> video_level_code_o == '0) else $error("not grounded");
    AST_LEVEL: assert property (
        !grounded_o |-> video_level_code_o[9:0] == 10'h3FF - video_code_o[9:0])
        else $error("level code wrong");
    AST_AUX_FRAME: assert property (
        $changed(aux_dac_code_o) |-> serial_frame_strobe_i)
        else $error("aux changed inside frame");
    AST_SER_HOLD: assert property (
        mode_source_select_i && !serial_frame_strobe_i ##1
        mode_source_select_i && !serial_frame_strobe_i |-> $stable(grounded_o))
        else $error("mode changed inside frame");
    cover property (transfer_start_strobe_i ##2 loading_o);
    cover property ($rose(grounded_o));
    cover property ($changed(aux_dac_code_o));
endmodule : dcl_props
bind dcl_loader dcl_props #(.CHANNELS(CHANNELS), .PIXEL_BITS(PIXEL_BITS))
    chk_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .transfer_start_strobe_i(transfer_start_strobe_i),
    .thermal_switch_input_i(thermal_switch_input_i),
    .mode_source_select_i(mode_source_select_i),
    .ground_switch_input_i(ground_switch_input_i),
    .serial_frame_strobe_i(serial_frame_strobe_i),
    .video_code_o(video_code_o), .video_level_code_o(video_level_code_o),
    .polarity_o(polarity_o), .grounded_o(grounded_o),
    .thermal_enable_o(thermal_enable_o), .aux_dac_code_o(aux_dac_code_o),
    .loading_o(loading_o));
`default_nettype wire

/* test/dcl_pix_source.sv */
// Pixel source standing in for the video timing controller.
`timescale 1ns/10ps
`default_nettype none
module dcl_pix_source (
    // Control from the bench.
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [9:0] base_i,
    // Pixel stream towards the block.
    input wire logic pix_ready_i,
    output logic pix_valid_o,
    output logic [9:0] pix_data_o
);
    int left = 0;
    logic valid_q = 1'b0;
    logic [9:0] data_q = 10'h000;
    assign pix_valid_o = valid_q;
    assign pix_data_o = data_q;
    // A released bus shows the inverse of its last word, so stale data is
    // never mistaken for a fresh one.
    always @(posedge clk_i) begin
        if (go_i) begin
            left <= 12;
            valid_q <= 1'b1;
            data_q <= base_i;
        end else if (valid_q && pix_ready_i) begin
            left <= left - 1;
            valid_q <= left > 1;
            data_q <= (left > 1) ? data_q + 10'h001 : ~data_q;
        end
    end
endmodule : dcl_pix_source
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench of the column loader control block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, resetn_i = 1'b0, strb = 1'b0, dir = 1'b0;
    logic pol = 1'b0, thr = 1'b0, msel = 1'b0, ground_switch_input = 1'b1, frm = 1'b1;
    logic sck = 1'b0, serial_data_in = 1'b0, go = 1'b0, valid, ready, polo, gnd, thro;
    logic busy;
    logic [9:0] base = 10'h000, data;
    logic [119:0] code;
    logic [7:0] aux;
    int err_total = 0, samples_checked = 0;
    initial forever #50 clk_i = ~clk_i;
    dcl_loader dut (.clk_i(clk_i), .resetn_i(resetn_i), .pix_valid_i(valid),
        .pix_data_i(data), .pix_ready_o(ready),
        .transfer_start_strobe_i(strb), .load_direction_i(dir),
        .polarity_control_i(pol), .thermal_switch_input_i(thr),
        .mode_source_select_i(msel), .ground_switch_input_i(ground_switch_input),
        .serial_frame_strobe_i(frm), .serial_clock_i(sck),
        .serial_data_in_i(serial_data_in), .video_code_o(code),
        .video_level_code_o(), .polarity_o(polo), .grounded_o(gnd),
        .thermal_enable_o(thro), .aux_dac_code_o(aux), .loading_o(busy));
    dcl_pix_source src (.clk_i(clk_i), .go_i(go), .base_i(base),
        .pix_ready_i(ready), .pix_valid_o(valid), .pix_data_o(data));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic chk(input string what, input logic [119:0] exp,
            input logic [119:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic pulse();
        @(posedge clk_i);
        strb <= 1'b1;
        go <= 1'b0;
        cyc(1);
        strb <= 1'b0;
        cyc(2);
    endtask : pulse
    task automatic t_load(input logic d, input logic p, input logic [9:0] b);
        logic [119:0] exp;
        dir <= d;
        pol <= p;
        base <= b;
        go <= 1'b1;
        pulse();
        pol <= ~p;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk_i);
        chk("loading", 120'h0, 120'(busy));
        pulse();
        for (int g = 0; g < 12; g++) exp[g*10+:10] = b + 10'(d ? 11 - g : g);
        chk("video", exp, code);
        chk("polarity", 120'(p), 120'(polo));
    endtask : t_load
    task automatic t_ser(input logic [11:0] w);
        @(posedge clk_i);
        frm <= 1'b0;
        for (int i = 11; i >= 0; i--) begin
            cyc(2);
            serial_data_in <= w[i];
            cyc(2);
            sck <= 1'b1;
            cyc(2);
            sck <= 1'b0;
        end
        cyc(2);
        frm <= 1'b1;
        serial_data_in <= ~serial_data_in;
        cyc(4);
    endtask : t_ser
    task automatic t_mode();
        thr <= 1'b1;
        ground_switch_input <= 1'b0;
        cyc(2);
        chk("ground", 120'h1, 120'(gnd));
        chk("thermal", 120'h1, 120'(thro));
        ground_switch_input <= 1'b1;
        msel <= 1'b1;
        t_ser(12'hFA5);
        chk("mode", 120'h1, 120'(gnd));
        chk("aux", 120'hA5, 120'(aux));
        ground_switch_input <= 1'b0;
        t_ser(12'h35A);
        chk("mode", 120'h0, 120'(gnd));
        chk("aux", 120'hA5, 120'(aux));
        msel <= 1'b0;
        ground_switch_input <= 1'b1;
        t_ser(12'hC3C);
        chk("mode", 120'h0, 120'(gnd));
        chk("aux", 120'h3C, 120'(aux));
    endtask : t_mode
    task automatic conclude();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        cyc(4);
        resetn_i <= 1'b1;
        t_load(1'b0, 1'b1, 10'h100);
        t_load(1'b1, 1'b0, 10'h2F0);
        t_mode();
        conclude();
    end
    initial begin
        cyc(2000);
        err_total++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
